// file: smbus_slave_alert_interface.sv
`timescale 1ns/100ps
module smbus_slave_alert_interface
  import smbus_slave_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = BUS_STUCK_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Alert line
  output logic alert_o,
  output logic alert_oe_n_o,
  // Address select pins
  input wire addr_sel_t sel_i,
  // Register file side
  input wire logic [FAULT_W-1:0] fault_i,
  input wire logic [FAULT_W-1:0] alert_en_i,
  input wire logic [7:0] reg_rdata_i,
  output reg_wr_t reg_wr_o,
  output logic [2:0] reg_ptr_o,
  output logic mass_write_en_o,
  output logic [7:0] dev_addr_o
);

  localparam logic [TO_W-1:0] TO_LIM = TO_W'(TIMEOUT_CYC);

  logic scl_m_q, scl_s_q, scl_d_q, sda_m_q, sda_s_q, sda_d_q;
  addr_sel_t sel_m_q, sel_s_q;
  logic [7:0] own_addr_q;
  bus_state_t state_q, next_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_sh_q, tx_sh_q, cmd_q;
  logic [2:0] ptr_q;
  logic drive_q, discard_q, ara_q, mack_ok_q, alert_q, mass_wen_q;
  logic [FAULT_W-1:0] pend_q;
  logic [TO_W-1:0] to_cnt_q;
  reg_wr_t reg_wr_q;
  logic scl_rise, scl_fall, start, stop, timeout, rx_state, rx_done;
  logic own_hit, mass_hit, ara_hit, cmd_ok, rx_ack, direct_hit, tx_end, cmd_take, wr_fire;
  bus_state_t rx_next;
  logic [FAULT_W-1:0] pend, pend_rise;
  logic [4:0] sel_idx;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // two-stage line sampling
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_d_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_d_q <= 1'b1;
      sel_m_q <= '0;
      sel_s_q <= '0;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_d_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_d_q <= sda_s_q;
      sel_m_q <= sel_i;
      sel_s_q <= sel_m_q;
    end
  end

  assign scl_rise = scl_s_q && !scl_d_q;
  assign scl_fall = !scl_s_q && scl_d_q;
  assign start = scl_s_q && scl_d_q && sda_d_q && !sda_s_q;
  assign stop = scl_s_q && scl_d_q && !sda_d_q && sda_s_q;

  // ---------------------------------------------------------------
  // Own address
  // ---------------------------------------------------------------
  assign sel_idx = 5'(sel_digit(sel_s_q.addr_select_pin_hi) * 5'h09
                    + sel_digit(sel_s_q.addr_select_pin_mid) * 5'h03
                    + sel_digit(sel_s_q.addr_select_pin_lo));

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      own_addr_q <= ADDR_LUT[0];
    end else begin
      own_addr_q <= ADDR_LUT[sel_idx];
    end
  end

  // ---------------------------------------------------------------
  // Bus-stuck timeout
  // ---------------------------------------------------------------
  // count low time
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      to_cnt_q <= '0;
    end else if (scl_s_q && sda_s_q) begin
      to_cnt_q <= '0;
    end else if (to_cnt_q != TO_LIM) begin
      to_cnt_q <= to_cnt_q + 1'b1;
    end
  end
  assign timeout = (to_cnt_q == TO_LIM);

  // ---------------------------------------------------------------
  // Byte decode
  // ---------------------------------------------------------------
  assign rx_state = (state_q == S_ADDR) || (state_q == S_CMD) || (state_q == S_WDATA);
  assign rx_done = rx_state && scl_fall && (bit_cnt_q == BITS_PER_BYTE);
  assign own_hit = (rx_sh_q[7:1] == own_addr_q[7:1]);
  assign mass_hit = (rx_sh_q == MASS_ADDR) && mass_wen_q;
  assign ara_hit = (rx_sh_q == ARA_ADDR) && alert_q;
  assign cmd_ok = (rx_sh_q >= CMD_FIRST) && (rx_sh_q <= CMD_LAST);
  assign direct_hit = (state_q == S_ADDR) && rx_done && own_hit;
  assign cmd_take = (state_q == S_CMD) && rx_done && cmd_ok;
  assign wr_fire = (state_q == S_WDATA) && rx_done && !discard_q;
  assign tx_end = (state_q == S_TX) && scl_fall && (bit_cnt_q == BITS_PER_BYTE);

  always_comb begin
    rx_ack = 1'b0;
    rx_next = S_IDLE;
    unique case (state_q)
      S_ADDR: begin
        if ((own_hit && rx_sh_q[0]) || ara_hit) begin
          rx_ack = 1'b1;
          rx_next = S_TX;
        end else if (own_hit || mass_hit) begin
          rx_ack = 1'b1;
          rx_next = S_CMD;
        end
      end
      S_CMD: begin
        rx_ack = cmd_ok;
        rx_next = S_WDATA;
      end
      S_WDATA: begin
        rx_ack = 1'b1;
        rx_next = S_WDATA;
      end
      default: begin
        rx_ack = 1'b0;
        rx_next = S_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Bus state machine
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= S_IDLE;
      next_q <= S_IDLE;
      bit_cnt_q <= '0;
      rx_sh_q <= '0;
      tx_sh_q <= '0;
      drive_q <= 1'b0;
      discard_q <= 1'b0;
      ara_q <= 1'b0;
      mack_ok_q <= 1'b0;
    end else if (timeout || stop) begin
      state_q <= S_IDLE;
      drive_q <= 1'b0;
    end else if (start) begin
      state_q <= S_ADDR;
      bit_cnt_q <= '0;
      drive_q <= 1'b0;
      discard_q <= 1'b0;
      ara_q <= 1'b0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          drive_q <= 1'b0;
        end
        S_ADDR, S_CMD, S_WDATA: begin
          if (scl_rise) begin
            rx_sh_q <= {rx_sh_q[6:0], sda_s_q};
            bit_cnt_q <= bit_cnt_q + 1'b1;
          end else if (rx_done) begin
            bit_cnt_q <= '0;
            drive_q <= rx_ack;
            state_q <= rx_ack ? S_ACK : S_IDLE;
            next_q <= rx_next;
            if (state_q == S_ADDR) begin
              ara_q <= ara_hit;
            end
            if (state_q == S_WDATA) begin
              discard_q <= 1'b1;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= '0;
            state_q <= next_q;
            if (next_q == S_TX) begin
              tx_sh_q <= ara_q ? own_addr_q : reg_rdata_i;
              drive_q <= ara_q ? !own_addr_q[7] : !reg_rdata_i[7];
            end else begin
              drive_q <= 1'b0;
            end
          end
        end
        S_TX: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 1'b1;
          end else if (tx_end) begin
            drive_q <= 1'b0;
            state_q <= ara_q ? S_IDLE : S_MACK;
          end else if (scl_fall) begin
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            drive_q <= !tx_sh_q[6];
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            mack_ok_q <= !sda_s_q;
          end else if (scl_fall) begin
            bit_cnt_q <= '0;
            if (mack_ok_q) begin
              tx_sh_q <= reg_rdata_i;
              drive_q <= !reg_rdata_i[7];
              state_q <= S_TX;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pointer, writes and mass-write enable
  // ---------------------------------------------------------------
  // pointer from command
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_q <= '0;
      cmd_q <= '0;
    end else if (cmd_take) begin
      ptr_q <= rx_sh_q[2:0];
      cmd_q <= rx_sh_q;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_wr_q <= '0;
      mass_wen_q <= MASS_EN_RST;
    end else begin
      reg_wr_q.valid <= wr_fire;
      if (wr_fire) begin
        reg_wr_q.ptr <= ptr_q;
        reg_wr_q.data <= rx_sh_q;
        if (cmd_q == CTRL2_CMD) begin
          mass_wen_q <= rx_sh_q[MASS_EN_BIT];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Alert line
  // ---------------------------------------------------------------
  assign pend = fault_i & alert_en_i;
  assign pend_rise = pend & ~pend_q;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_q <= '0;
      alert_q <= 1'b0;
    end else begin
      pend_q <= pend;
      if (|pend_rise) begin
        alert_q <= 1'b1;
      end else if (direct_hit || (tx_end && ara_q)) begin
        alert_q <= 1'b0;
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n_o = !drive_q;
  assign alert_o = 1'b0;
  assign alert_oe_n_o = !alert_q;
  assign reg_wr_o = reg_wr_q;
  assign reg_ptr_o = ptr_q;
  assign mass_write_en_o = mass_wen_q;
  assign dev_addr_o = own_addr_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  AST_ADDR_RANGE: assert property (
    !own_addr_q[0] && (own_addr_q >= 8'h88) && (own_addr_q <= 8'hEC))
    else $error("own address outside select map");
  AST_MASS_ON: assert property (
    state_q == S_ADDR && rx_done && !start && !stop && !timeout
      && rx_sh_q == MASS_ADDR && mass_wen_q |=> state_q == S_ACK && !sda_oe_n_o)
    else $error("mass write not acked");
  AST_MASS_OFF: assert property (
    state_q == S_ADDR && rx_done && rx_sh_q == MASS_ADDR && !mass_wen_q
      |=> state_q != S_ACK && sda_oe_n_o)
    else $error("disabled mass write acked");
  AST_ARA_REPLY: assert property (
    state_q == S_ACK && next_q == S_TX && ara_q && scl_fall && !start && !stop && !timeout
      |=> tx_sh_q == own_addr_q)
    else $error("alert reply is not own address");
  AST_ACK_DRIVE: assert property (
    state_q == S_ACK |-> !sda_oe_n_o)
    else $error("ack slot not driven");
  AST_PTR_LOAD: assert property (
    cmd_take && !start && !stop && !timeout |=> ptr_q == $past(rx_sh_q[2:0]))
    else $error("pointer not loaded");
  AST_WRITE_ONCE: assert property (
    wr_fire |=> reg_wr_o.valid && reg_wr_o.data == $past(rx_sh_q) ##1 !reg_wr_o.valid)
    else $error("write strobe wrong");
  AST_DISCARD: assert property (
    state_q == S_WDATA && discard_q && rx_done |=> !reg_wr_o.valid)
    else $error("second data byte written");
  AST_READ_REPEAT: assert property (
    state_q == S_MACK && scl_fall && mack_ok_q && !start && !stop && !timeout
      |=> state_q == S_TX && tx_sh_q == $past(reg_rdata_i))
    else $error("word read did not repeat register");
  AST_ALERT_SET: assert property (
    |pend_rise |=> alert_q && !alert_oe_n_o)
    else $error("alert not asserted");
  AST_ALERT_DIRECT: assert property (
    direct_hit && !(|pend_rise) |=> !alert_q)
    else $error("direct address kept alert");
  AST_NO_REALERT: assert property (
    !alert_q && !(|pend_rise) |=> !alert_q)
    else $error("alert without new fault");
  AST_TIMEOUT: assert property (
    timeout |=> state_q == S_IDLE && sda_oe_n_o)
    else $error("stuck bus not released");
  AST_CMD_NACK: assert property (
    state_q == S_CMD && rx_done && !cmd_ok |=> state_q != S_ACK && sda_oe_n_o)
    else $error("unsupported command acked");

  COV_WRITE: cover property (wr_fire);
  COV_WORD_READ: cover property (state_q == S_MACK && scl_fall && mack_ok_q);
  COV_ARA: cover property (tx_end && ara_q);
  COV_MASS: cover property (state_q == S_ADDR && rx_done && mass_hit);

endmodule

// file: smbus_slave_pkg.sv
package smbus_slave_pkg;

  // -----------------------------------------------------------------
  // Clock and timing
  // -----------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned BUS_STUCK_MS = 25;
  localparam int unsigned BUS_STUCK_CYC = BUS_STUCK_MS * CLK_KHZ;
  localparam int TO_W = 24;

  // -----------------------------------------------------------------
  // Bus addresses and command space
  // -----------------------------------------------------------------
  localparam logic [7:0] MASS_ADDR = 8'hC6;
  localparam logic [7:0] ARA_ADDR = 8'h19;
  localparam logic [7:0] CMD_FIRST = 8'hD0;
  localparam logic [7:0] CMD_LAST = 8'hE4;
  localparam logic [7:0] CTRL2_CMD = 8'hD4;
  localparam int MASS_EN_BIT = 4;
  localparam logic MASS_EN_RST = 1'b1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int FAULT_W = 16;

  // Index is hi*9 + mid*3 + lo, digit low=0, high=1, open=2
  localparam logic [7:0] ADDR_LUT [0:26] = '{
    8'h98, 8'h9E, 8'h9C, 8'hE8, 8'h9A, 8'h8A, 8'h88, 8'h8E, 8'h8C,
    8'hD8, 8'hDE, 8'hDC, 8'hEC, 8'hDA, 8'hCA, 8'hC8, 8'hCE, 8'hCC,
    8'hB8, 8'hBE, 8'hBC, 8'hEA, 8'hBA, 8'hAA, 8'hA8, 8'hAE, 8'hAC};

  // -----------------------------------------------------------------
  // Types
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_LOW = 2'h0,
    SEL_HIGH = 2'h1,
    SEL_OPEN = 2'h2
  } sel_t;

  typedef struct packed {
    logic [1:0] addr_select_pin_hi;
    logic [1:0] addr_select_pin_mid;
    logic [1:0] addr_select_pin_lo;
  } addr_sel_t;

  typedef struct packed {
    logic valid;
    logic [2:0] ptr;
    logic [7:0] data;
  } reg_wr_t;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_CMD,
    S_WDATA,
    S_ACK,
    S_TX,
    S_MACK
  } bus_state_t;

  function automatic logic [4:0] sel_digit(input logic [1:0] s);
    if (s == SEL_LOW) return 5'h00;
    if (s == SEL_HIGH) return 5'h01;
    return 5'h02;
  endfunction

endpackage

// file: bus_master_model.sv
`timescale 1ns/100ps
module bus_master_model (
  // Bus lines
  output logic scl_o,
  output logic sda_drv_n_o,
  input wire logic sda_i
);
  // --------
  // Bit and frame timing, 80 ns clock period
  // --------
  initial begin
    scl_o = 1'b1;
    sda_drv_n_o = 1'b1;
  end

  task automatic start;
    #20 sda_drv_n_o = 1'b1;
    #20 scl_o = 1'b1;
    #20 sda_drv_n_o = 1'b0;
    #20 scl_o = 1'b0;
  endtask

  task automatic stop;
    #20 sda_drv_n_o = 1'b0;
    #20 scl_o = 1'b1;
    #20 sda_drv_n_o = 1'b1;
    #40;
  endtask

  task automatic put_bit(input logic b, output logic r);
    #20 sda_drv_n_o = b;
    #20 scl_o = 1'b1;
    #20 r = sda_i;
    #20 scl_o = 1'b0;
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], r);
    end
    put_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, r);
      b[i] = r;
    end
    put_bit(~mack, r);
  endtask
endmodule

// file: tb.sv
`timescale 1ns/100ps
module tb;
  import smbus_slave_pkg::*;
  localparam int unsigned TO_CYC = 1000;
  localparam logic [7:0] TBL [0:26] = '{
    8'h98, 8'h9E, 8'h9C, 8'hE8, 8'h9A, 8'h8A, 8'h88, 8'h8E, 8'h8C,
    8'hD8, 8'hDE, 8'hDC, 8'hEC, 8'hDA, 8'hCA, 8'hC8, 8'hCE, 8'hCC,
    8'hB8, 8'hBE, 8'hBC, 8'hEA, 8'hBA, 8'hAA, 8'hA8, 8'hAE, 8'hAC};
  logic mclk, nrst_n, scl, sda_drv_n, sda, sda_o, sda_oe_n, alert_o, alert_oe_n, mass_en;
  addr_sel_t sel;
  logic [FAULT_W-1:0] fault, alert_en;
  logic [7:0] rdata, dev_addr, own, c, b0, b1;
  logic [2:0] ptr, a3;
  logic k, r;
  reg_wr_t reg_wr;
  int errors, cmp_count, wr_cnt, cyc, n, nb, j;

  // --------
  // Wired bus, device and master
  // --------
  assign sda = sda_drv_n & (sda_oe_n | sda_o);

  smbus_slave_alert_interface #(.TIMEOUT_CYC(TO_CYC)) u_dut (
    .mclk_i(mclk), .nrst_i(nrst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n), .sel_i(sel),
    .fault_i(fault), .alert_en_i(alert_en), .reg_rdata_i(rdata), .reg_wr_o(reg_wr),
    .reg_ptr_o(ptr), .mass_write_en_o(mass_en), .dev_addr_o(dev_addr));

  bus_master_model u_mst (.scl_o(scl), .sda_drv_n_o(sda_drv_n), .sda_i(sda));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (reg_wr.valid === 1'b1) wr_cnt <= wr_cnt + 1;
    if (cyc == 40000) begin
      errors = errors + 1;
      end_of_test;
    end
  end

  task automatic tick(input int cnt);
    repeat (cnt) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  function automatic int dig(input logic [1:0] v);
    return (v == 2'h3) ? 2 : int'(v);
  endfunction

  function automatic logic [7:0] exp_addr(input addr_sel_t s);
    return TBL[dig(s.addr_select_pin_hi) * 9 + dig(s.addr_select_pin_mid) * 3
               + dig(s.addr_select_pin_lo)];
  endfunction

  task automatic wr_xfer(input logic [7:0] a, input logic [7:0] cm, input logic [7:0] dt,
                         input int nd, output logic [2:0] acks);
    logic ak;
    u_mst.start;
    u_mst.send(a, acks[0]);
    u_mst.send(cm, acks[1]);
    acks[2] = 1'b1;
    repeat (nd) begin
      u_mst.send(dt, ak);
      acks[2] = acks[2] & ak;
      dt = ~dt;
    end
    u_mst.stop;
  endtask

  task automatic rd_xfer(input logic [7:0] cm, input int nbytes, output logic [2:0] acks,
                         output logic [7:0] r0, output logic [7:0] r1);
    r1 = 8'h00;
    u_mst.start;
    u_mst.send(own, acks[0]);
    u_mst.send(cm, acks[1]);
    u_mst.start;
    u_mst.send(own | 8'h01, acks[2]);
    u_mst.recv(nbytes > 1, r0);
    if (nbytes > 1) u_mst.recv(1'b0, r1);
    u_mst.stop;
  endtask

  task automatic ara_xfer(output logic ak, output logic [7:0] rb);
    rb = 8'h00;
    u_mst.start;
    u_mst.send(8'h19, ak);
    if (ak === 1'b1) u_mst.recv(1'b0, rb);
    u_mst.stop;
  endtask

  // --------
  // Main sequence
  // --------
  initial begin
    nrst_n = 1'b0;
    sel = '0;
    fault = '0;
    alert_en = '0;
    rdata = '0;
    void'($urandom(32'h2EF6EA38));
    tick(20);
    nrst_n = 1'b1;
    tick(5);
    chk("mass_en_rst", 8'h01, 8'(mass_en));
    for (int i = 0; i < 64; i++) begin
      sel = 6'(i);
      tick(4);
      chk("dev_addr", exp_addr(sel), dev_addr);
    end
    sel = {2'($urandom % 3), 2'($urandom % 3), 2'($urandom % 3)};
    own = exp_addr(sel);
    tick(4);
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 8'hD0 : (i == 1) ? 8'hE4 : 8'hD0 + 8'($urandom % 21);
      b0 = 8'($urandom);
      n = wr_cnt;
      wr_xfer(own, c, b0, 1 + int'($urandom % 2), a3);
      chk("wr_ack", 8'h07, 8'(a3));
      chk("wr_count", 8'(n + 1), 8'(wr_cnt));
      chk("wr_ptr", 8'(c[2:0]), 8'(reg_wr.ptr));
      chk("wr_data", b0, reg_wr.data);
      if (c == 8'hD4) chk("mass_en", 8'(b0[4]), 8'(mass_en));
    end
    repeat (6) begin
      c = 8'hD0 + 8'($urandom % 21);
      nb = 1 + int'($urandom % 2);
      tick(1);
      rdata = 8'($urandom);
      rd_xfer(c, nb, a3, b0, b1);
      chk("rd_ack", 8'h07, 8'(a3));
      chk("rd_ptr", 8'(c[2:0]), 8'(ptr));
      chk("rd_byte0", rdata, b0);
      if (nb == 2) chk("rd_byte1", rdata, b1);
    end
    for (int i = 0; i < 3; i++) begin
      n = wr_cnt;
      wr_xfer((i == 2) ? own ^ 8'h10 : own, (i == 0) ? 8'hCF : 8'hE5, 8'hA5, 1, a3);
      chk("refused_ack", (i == 2) ? 8'h00 : 8'h01, 8'(a3));
      chk("refused_wr", 8'(n), 8'(wr_cnt));
    end
    wr_xfer(own, 8'hD4, 8'h10, 1, a3);
    chk("mass_en_on", 8'h01, 8'(mass_en));
    wr_xfer(8'hC6, 8'hD4, 8'hEF, 1, a3);
    chk("mass_ack", 8'h07, 8'(a3));
    chk("mass_en_off", 8'h00, 8'(mass_en));
    n = wr_cnt;
    wr_xfer(8'hC6, 8'hD0, 8'h5A, 1, a3);
    chk("mass_off_ack", 8'h00, 8'(a3));
    chk("mass_off_wr", 8'(n), 8'(wr_cnt));
    tick(1);
    j = int'($urandom % 16);
    alert_en = ~(16'h1 << j);
    fault = 16'h1 << j;
    tick(4);
    chk("alert_masked", 8'h01, 8'(alert_oe_n));
    ara_xfer(k, b0);
    chk("ara_idle_ack", 8'h00, 8'(k));
    tick(1);
    fault = '0;
    tick(1);
    alert_en = '1;
    tick(1);
    fault = 16'h1 << j;
    tick(3);
    chk("alert_set", 8'h00, 8'(alert_oe_n));
    ara_xfer(k, b0);
    chk("ara_ack", 8'h01, 8'(k));
    chk("ara_addr", own, b0);
    chk("ara_release", 8'h01, 8'(alert_oe_n));
    chk("alert_level", 8'h00, 8'(alert_o));
    chk("sda_level", 8'h00, 8'(sda_o));
    tick(50);
    chk("alert_held_off", 8'h01, 8'(alert_oe_n));
    fault = fault | (16'h1 << ((j + 1) % 16));
    tick(3);
    chk("alert_new_bit", 8'h00, 8'(alert_oe_n));
    wr_xfer(own, 8'hD1, 8'h00, 1, a3);
    chk("alert_direct", 8'h01, 8'(alert_oe_n));
    tick(1);
    fault = '0;
    tick(2);
    fault = 16'h1 << j;
    tick(3);
    chk("alert_rearm", 8'h00, 8'(alert_oe_n));
    u_mst.start;
    for (int i = 7; i >= 0; i--) u_mst.put_bit(own[i], r);
    tick(10);
    chk("stuck_ack", 8'h00, 8'(sda_oe_n));
    tick(TO_CYC + 20);
    chk("stuck_release", 8'h01, 8'(sda_oe_n));
    u_mst.stop;
    wr_xfer(own, 8'hD0, 8'h3C, 1, a3);
    chk("after_stuck_ack", 8'h07, 8'(a3));
    end_of_test;
  end
endmodule
